//--- include/tmr_pkg.sv
package tmr_pkg;
  localparam logic [7:0] TMR_ADDR_PRESCALE = 8'hD2;
  localparam logic [7:0] TMR_ADDR_COUNT = 8'hD3;
  localparam logic [7:0] TMR_ADDR_STATUS = 8'hD4;
  localparam logic [6:0] TMR_PRESCALE_RELOAD = 7'h7F;
  localparam logic [7:0] TMR_COUNT_RELOAD = 8'hFF;
  localparam logic [7:0] TMR_STATUS_RESET = 8'h00;
  localparam logic [7:0] TMR_ZERO8 = 8'h00;
  localparam int TMR_CORE_DIV = 12;
  localparam int TMR_BIT_FLAG = 7;
  typedef struct packed {
    logic underflow_flag;
    logic underflow_irq_enable;
    logic pin_direction_select;
    logic data_bit;
    logic prescaler_run;
    logic [2:0] tap_select;
  } tmr_status_s;
  typedef enum logic [2:0] {
    TMR_MODE_EVENT = 3'b001,
    TMR_MODE_GATED = 3'b010,
    TMR_MODE_OUTPUT = 3'b100
  } tmr_mode_e;
endpackage : tmr_pkg

//--- design/tmr_sync.sv
`timescale 1ns/1ps
module tmr_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic stage1;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Idle pin is pulled high, so start there to avoid a false edge
      stage1 <= 1'b1;
      dout <= 1'b1;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : tmr_sync

//--- design/tmr_div.sv
`timescale 1ns/1ps
module tmr_div #(
  parameter int DIV = 12
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Enable and tick
  input wire logic run,
  output logic tick
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (run) begin
      tick <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + W'(1);
    end else begin
      tick <= 1'b0;
    end
  end
endmodule : tmr_div

//--- design/tmr_top.sv
`timescale 1ns/1ps
module tmr_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Power state
  input wire logic stop_mode,
  // Timer pin
  input wire logic timer_pin_in,
  output logic timer_pin_out,
  output logic timer_pin_oe,
  // Interrupt request and wake
  output logic irq,
  // Status view
  output tmr_pkg::tmr_status_s status
);
  import tmr_pkg::*;

  tmr_status_s ctl;
  logic [6:0] prescaler;
  logic [7:0] counter;
  logic pin_sync;
  logic pin_prev;
  logic core_tick;
  logic freeze;
  logic pin_rise;
  logic pre_dec;
  logic [6:0] next_prescaler;
  logic count_en;
  logic wr_cnt;
  logic wr_pre;
  logic wr_stat;
  logic hw_zero;
  logic flag_set;
  logic flag_prev;
  tmr_mode_e mode;

  tmr_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .din(timer_pin_in),
    .dout(pin_sync)
  );

  // Wait has no input here: the core clock divider only stops in stop state
  tmr_div #(.DIV(TMR_CORE_DIV)) u_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(!stop_mode),
    .tick(core_tick)
  );

  // Mode decode
  always_comb begin
    if (ctl.pin_direction_select) begin
      mode = TMR_MODE_OUTPUT;
    end else if (ctl.data_bit) begin
      mode = TMR_MODE_GATED;
    end else begin
      mode = TMR_MODE_EVENT;
    end
  end

  assign freeze = stop_mode && (mode != TMR_MODE_EVENT);
  assign pin_rise = pin_sync && !pin_prev;

  // Prescaler source selection
  always_comb begin
    case (mode)
      TMR_MODE_EVENT: pre_dec = pin_rise;
      TMR_MODE_GATED: pre_dec = core_tick && pin_sync;
      TMR_MODE_OUTPUT: pre_dec = core_tick;
      default: pre_dec = 1'b0;
    endcase
  end

  assign next_prescaler = (prescaler == 7'h00) ? TMR_PRESCALE_RELOAD : prescaler - 7'h01;
  // Tap n fires when bit n-1 falls (tap 0 on every input), giving input divided by 2^n
  assign count_en = ctl.prescaler_run && pre_dec && !freeze &&
                    (ctl.tap_select == 3'h0 ||
                     (prescaler[ctl.tap_select - 3'h1] && !next_prescaler[ctl.tap_select - 3'h1]));
  assign wr_pre = wr && addr == TMR_ADDR_PRESCALE;
  assign wr_cnt = wr && addr == TMR_ADDR_COUNT;
  assign wr_stat = wr && addr == TMR_ADDR_STATUS;
  assign hw_zero = count_en && counter == 8'h01 && !wr_cnt;
  assign flag_set = hw_zero || (wr_cnt && wdata == TMR_ZERO8);

  // Pin history for edge detection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  // Prescaler
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prescaler <= TMR_PRESCALE_RELOAD;
    end else if (!ctl.prescaler_run) begin
      prescaler <= TMR_PRESCALE_RELOAD;
    end else if (wr_pre) begin
      prescaler <= wdata[6:0];
    end else if (pre_dec && !freeze) begin
      prescaler <= next_prescaler;
    end
  end

  // Counter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      counter <= TMR_COUNT_RELOAD;
    end else if (wr_cnt) begin
      counter <= wdata;
    end else if (count_en) begin
      counter <= (counter == TMR_ZERO8) ? TMR_COUNT_RELOAD : counter - 8'h01;
    end
  end

  // Status and control
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= tmr_status_s'(TMR_STATUS_RESET);
    end else begin
      if (wr_stat) begin
        ctl <= tmr_status_s'(wdata);
      end
      if (flag_set) begin
        ctl.underflow_flag <= 1'b1;
      end
    end
  end

  // Pin drive: data latched on flag rising edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flag_prev <= 1'b0;
      timer_pin_out <= 1'b0;
      timer_pin_oe <= 1'b0;
    end else begin
      flag_prev <= ctl.underflow_flag;
      if (ctl.underflow_flag && !flag_prev) begin
        timer_pin_out <= ctl.data_bit;
      end
      timer_pin_oe <= ctl.pin_direction_select;
    end
  end

  // Interrupt and status view
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
      status <= tmr_status_s'(TMR_STATUS_RESET);
    end else begin
      irq <= ctl.underflow_flag && ctl.underflow_irq_enable;
      status <= ctl;
    end
  end

  // Read port
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        TMR_ADDR_PRESCALE: rdata <= {1'b0, prescaler};
        TMR_ADDR_COUNT: rdata <= counter;
        TMR_ADDR_STATUS: rdata <= ctl;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : tmr_top

//--- dv/tmr_chk.sv
`timescale 1ns/1ps
module tmr_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Pin, request, status
  input wire logic timer_pin_out,
  input wire logic timer_pin_oe,
  input wire logic irq,
  input wire tmr_pkg::tmr_status_s status
);
  import tmr_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence soft_set_s;
    wr && (addr == TMR_ADDR_COUNT && wdata == TMR_ZERO8 || addr == TMR_ADDR_STATUS && wdata[7]);
  endsequence
  sequence flag_up_s;
    ##2 status.underflow_flag;
  endsequence
  rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  psc_msb_a: assert property (rd && addr == TMR_ADDR_PRESCALE |=> !rdata[7])
    else $error("prescaler bit 7 set");
  psc_init_a: assert property (rd && addr == TMR_ADDR_PRESCALE && !status.prescaler_run
    && !$past(status.prescaler_run) |=> rdata == 8'h7F) else $error("prescaler not forced");
  flag_set_a: assert property (soft_set_s |-> flag_up_s) else $error("flag not set");
  irq_flag_a: assert property (irq == (status.underflow_flag && status.underflow_irq_enable))
    else $error("irq wrong");
  oe_dir_a: assert property (timer_pin_oe == status.pin_direction_select) else $error("oe");
  pin_latch_a: assert property ($rose(status.underflow_flag) |-> timer_pin_out == status.data_bit)
    else $error("pin not latched");
  pin_hold_a: assert property (!$rose(status.underflow_flag) |-> $stable(timer_pin_out))
    else $error("pin moved");
endmodule : tmr_chk
bind tmr_top tmr_chk u_chk (.mclk, .reset_n, .addr, .wdata, .wr, .rd, .rdata,
  .timer_pin_out, .timer_pin_oe, .irq, .status);

//--- dv/tmr_pin_src.sv
`timescale 1ns/1ps
module tmr_pin_src (
  // Clock
  input wire logic mclk,
  // Device drive
  input wire logic drv_oe,
  input wire logic drv_val,
  // Pin level
  output logic pin
);
  logic lvl = 1'b1;
  // Pull-up while released, device level while driven
  assign pin = drv_oe ? drv_val : lvl;
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk) lvl <= 1'b0;
      repeat (3) @(posedge mclk);
      lvl <= 1'b1;
      repeat (4) @(posedge mclk);
    end
  endtask : pulses
  // Park the external level until told otherwise
  task automatic drive(input logic val);
    @(posedge mclk) lvl <= val;
  endtask : drive
endmodule : tmr_pin_src

//--- dv/tb_tmr_top.sv
`timescale 1ns/1ps
module tb_tmr_top;
  import tmr_pkg::*;
  localparam logic [7:0] AP = TMR_ADDR_PRESCALE;
  localparam logic [7:0] AC = TMR_ADDR_COUNT;
  localparam logic [7:0] AS = TMR_ADDR_STATUS;
  logic mclk = 0, reset_n = 0, wr = 0, rd = 0, rd_d = 0, stop_mode = 1;
  logic [7:0] addr = 0, wdata = 0, v, rdata;
  logic pin, pin_out, pin_oe, irq;
  tmr_status_s status;
  logic [7:0] exp_q[$];
  int n_errors = 0, samples_checked = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  tmr_top dut (.mclk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .stop_mode,
    .timer_pin_in(pin), .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .irq, .status);
  tmr_pin_src src (.mclk, .drv_oe(pin_oe), .drv_val(pin_out), .pin);
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  // One write or read cycle; a read notes its expected data
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge mclk) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (rd_d) cmp("rdata", exp_q.pop_front(), rdata);
    if (cyc == 30000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    int p;
    void'($urandom(91178));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    bus(0, AP, 8'h7F);
    bus(0, AC, 8'hFF);
    bus(0, AS, TMR_STATUS_RESET);
    bus(0, 8'h5A, 8'h00);
    // Gated mode, stopped: nothing counts
    bus(1, AS, 8'h18);
    v = 8'($urandom_range(255, 1));
    bus(1, AC, v);
    bus(0, AC, v);
    v = 8'($urandom_range(127));
    bus(1, AP, v);
    src.pulses(2);
    bus(0, AP, v);
    bus(1, AC, 8'h00);
    bus(0, AS, 8'h98);
    bus(1, AS, 8'hD8);
    bus(0, AS, 8'hD8);
    cmp("irq", 8'h01, 8'(irq));
    // Event mode, every tap, three counts each
    for (int n = 0; n < 8; n++) begin
      bus(1, AS, 8'(n));
      bus(1, AC, 8'hFF);
      bus(0, AP, 8'h7F);
      bus(1, AS, 8'(n + 8));
      p = 3 << n;
      src.pulses(p);
      bus(0, AC, 8'hFC);
      bus(0, AP, 8'((127 - p) & 127));
    end
    bus(1, AS, 8'h08);
    bus(1, AC, 8'h01);
    src.pulses(2);
    bus(0, AC, 8'hFF);
    bus(0, AS, 8'h88);
    cmp("irq", 8'h00, 8'(irq));
    // Output mode from the core clock divided by 12
    stop_mode <= 1'b0;
    bus(1, AS, 8'h38);
    bus(1, AC, 8'h02);
    repeat (8) @(negedge mclk);
    cmp("flag", 8'h00, 8'(status.underflow_flag));
    for (int i = 0; i < 40 && status.underflow_flag !== 1'b1; i++) @(negedge mclk);
    repeat (2) @(negedge mclk);
    cmp("pin", 8'h01, 8'(pin));
    bus(1, AS, 8'h28);
    bus(1, AC, 8'h00);
    repeat (4) @(negedge mclk);
    cmp("pin", 8'h00, 8'(pin));
    // Gated mode running: pin low holds the prescaler, pin high passes one tick in 12
    bus(1, AS, 8'h18);
    src.drive(1'b0);
    repeat (4) @(posedge mclk);
    v = 8'($urandom_range(127, 1));
    bus(1, AP, v);
    repeat (11) @(posedge mclk);
    bus(0, AP, v);
    src.drive(1'b1);
    repeat (4) @(posedge mclk);
    bus(1, AP, v);
    repeat (11) @(posedge mclk);
    bus(0, AP, v - 8'h01);
    end_sim();
  end
endmodule : tb_tmr_top
